// >>> design/gci_config.sv
// Configuration front end of a programmable-gain amplifier.
// Assumes all pins are asynchronous to clk; serial clock is sampled.
//
// Functional notes
// - Mode from comparing the two level pins
// - Parallel mode ignores the internal control register
// - Parallel gain and power-down from shared pins
// - Parallel power-down follows pin high level
// - Fault detection disabled in parallel mode
// - Gain codes 000..110 give 10 to 1000
// - Code 111 selects external resistor path
// - Serial mode controls every function via register
// - Host drives clock, data, select; device drives out
// - Sixteen-bit control register written only serially
// - Parallel compensation code derived from gain code
// - Falling select arms shift; clock high at edges
// - Shift one bit per rising serial clock
// - Rising select copies shift into holding register
`timescale 1ns/1ns
`default_nettype none
module gci_config (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        mode_level_pin_a,
  input  wire logic                        mode_level_pin_b,
  input  wire logic                        select_n,
  input  wire logic                        serial_clk,
  input  wire logic                        serial_in,
  input  wire logic                        serial_out_in,
  output logic                             serial_out,
  output logic                             serial_out_oe,
  output logic                             serial_mode,
  output logic [gci_pkg::GAIN_W-1:0]       gain_code,
  output logic [gci_pkg::GV_W-1:0]         gain_value,
  output logic                             ext_gain_path,
  output logic [gci_pkg::COMP_W-1:0]       comp_code,
  output logic [gci_pkg::MUX_W-1:0]        mux_sel,
  output logic                             polarity_swap,
  output logic                             power_down,
  output logic                             filter_en,
  output logic                             fault_pin_sel,
  output logic [gci_pkg::FCUR_W-1:0]       fault_current,
  output logic [gci_pkg::CTRL_W-1:0]       ctrl_word
);
  import gci_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Synchronised pins
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic              lvl_a_s;
  logic              lvl_b_s;
  logic              sel_s;
  logic              sck_s;
  logic              sdi_s;
  logic              g0_s;

  assign pins_async = {serial_out_in, serial_in, serial_clk, select_n,
                       mode_level_pin_b, mode_level_pin_a};

  gci_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  assign lvl_a_s = pins_sync[0];
  assign lvl_b_s = pins_sync[1];
  assign sel_s   = pins_sync[2];
  assign sck_s   = pins_sync[3];
  assign sdi_s   = pins_sync[4];
  assign g0_s    = pins_sync[5];

  // Shared pins under their parallel-mode meaning
  wire              power_down_pin = sel_s;
  wire              gain_sel_msb   = sck_s;
  wire              gain_sel_mid   = sdi_s;
  wire              gain_sel_lsb   = g0_s;
  wire [GAIN_W-1:0] pin_gain       = {gain_sel_msb, gain_sel_mid, gain_sel_lsb};

  // State
  gci_mode_t         mode_reg;
  gci_mode_t         mode_next;
  logic              sel_prev_reg;
  logic              sck_prev_reg;
  logic              armed_reg;
  logic              armed_next;
  logic [CTRL_W-1:0] shift_reg;
  logic [CTRL_W-1:0] shift_next;
  logic [CTRL_W-1:0] hold_reg;
  logic [CTRL_W-1:0] hold_next;
  logic [CTRL_W-1:0] eff_reg;
  logic [CTRL_W-1:0] eff_next;
  logic              sdo_reg;
  logic [GV_W-1:0]   gval_reg;
  logic              ext_reg;

  // Mode decode: level pins compared, equal levels keep the last mode
  wire lvl_ser = !lvl_a_s && lvl_b_s;
  wire lvl_par = lvl_a_s && !lvl_b_s;
  assign mode_next = lvl_par ? MODE_PARALLEL :
                     lvl_ser ? MODE_SERIAL : mode_reg;
  wire is_ser = (mode_reg == MODE_SERIAL);

  // Edge detection on sampled link pins
  wire sel_fall = sel_prev_reg && !sel_s;
  wire sel_rise = !sel_prev_reg && sel_s;
  wire sck_rise = !sck_prev_reg && sck_s;
  wire do_shift = is_ser && armed_reg && !sel_s && sck_rise;
  wire do_load  = is_ser && armed_reg && sel_rise;

  // Arm on falling select, disarm on rising select or leaving serial
  always_comb begin
    armed_next = armed_reg;
    case (mode_reg)
      MODE_SERIAL: begin
        if (sel_fall) begin
          armed_next = 1'b1;
        end else if (sel_rise) begin
          armed_next = 1'b0;
        end
      end
      MODE_PARALLEL: begin
        armed_next = 1'b0;
      end
      default: begin
        armed_next = 1'b0;
      end
    endcase
  end

  // MSB first in, far end out, so chained devices pass the stream on
  assign shift_next = do_shift ? {shift_reg[CTRL_W-2:0], sdi_s} : shift_reg;
  assign hold_next  = do_load ? shift_reg : hold_reg;

  // Parallel word: pins plus auto compensation, every other field off
  logic [COMP_W-1:0] pin_comp;
  logic [CTRL_W-1:0] par_word;

  gci_gain_decode u_pin_dec (
    .gain_code  (pin_gain),
    .gain_value (),
    .comp_auto  (pin_comp),
    .ext_path   ()
  );

  always_comb begin
    par_word                            = CTRL_RST;
    par_word[GAIN_LSB +: GAIN_W]        = pin_gain;
    par_word[COMP_LSB +: COMP_W]        = pin_comp;
    par_word[PD_BIT]                    = power_down_pin;
  end

  // Holding register never reaches the outputs in parallel mode
  assign eff_next = is_ser ? hold_reg : par_word;

  // Gain factor of the applied word
  logic [GV_W-1:0] eff_gval;
  logic            eff_ext;

  gci_gain_decode u_eff_dec (
    .gain_code  (eff_reg[GAIN_LSB +: GAIN_W]),
    .gain_value (eff_gval),
    .comp_auto  (),
    .ext_path   (eff_ext)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg     <= MODE_SERIAL;
      sel_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b1;
      armed_reg    <= 1'b0;
    end else begin
      mode_reg     <= mode_next;
      sel_prev_reg <= sel_s;
      sck_prev_reg <= sck_s;
      armed_reg    <= armed_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= CTRL_RST;
      hold_reg  <= CTRL_RST;
      eff_reg   <= CTRL_RST;
    end else begin
      shift_reg <= shift_next;
      hold_reg  <= hold_next;
      eff_reg   <= eff_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdo_reg  <= 1'b0;
      gval_reg <= GV_X10;
      ext_reg  <= 1'b0;
    end else begin
      sdo_reg  <= shift_reg[CTRL_W-1];
      gval_reg <= eff_gval;
      ext_reg  <= eff_ext;
    end
  end

  // Outputs
  assign serial_out    = sdo_reg;
  assign serial_out_oe = is_ser && armed_reg;
  assign serial_mode   = is_ser;
  assign gain_code     = eff_reg[GAIN_LSB +: GAIN_W];
  assign gain_value    = gval_reg;
  assign ext_gain_path = ext_reg;
  assign comp_code     = eff_reg[COMP_LSB +: COMP_W];
  assign mux_sel       = eff_reg[MUX_LSB +: MUX_W];
  assign polarity_swap = eff_reg[POL_BIT];
  assign power_down    = eff_reg[PD_BIT];
  assign filter_en     = eff_reg[FILT_BIT];
  assign fault_pin_sel = eff_reg[FPIN_BIT];
  assign fault_current = eff_reg[FCUR_LSB +: FCUR_W];
  assign ctrl_word     = eff_reg;

  // Checks
  property p_mode_sel;
    (lvl_a_s && !lvl_b_s) |=> (mode_reg == MODE_PARALLEL) && !serial_mode;
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("parallel levels not honoured");

  property p_par_ignore;
    (mode_reg == MODE_PARALLEL) |=>
      (eff_reg[MUX_LSB +: MUX_W] == 2'h0) && !eff_reg[POL_BIT] && !eff_reg[FILT_BIT];
  endproperty
  a_par_ignore: assert property (p_par_ignore) else $error("register leaked in parallel mode");

  property p_par_gain;
    (mode_reg == MODE_PARALLEL) |=> (gain_code == $past(pin_gain));
  endproperty
  a_par_gain: assert property (p_par_gain) else $error("parallel gain not from pins");

  property p_par_pd;
    (mode_reg == MODE_PARALLEL) |=> (power_down == $past(power_down_pin));
  endproperty
  a_par_pd: assert property (p_par_pd) else $error("power-down pin not obeyed");

  property p_par_fault;
    (mode_reg == MODE_PARALLEL) |=> !fault_pin_sel && (fault_current == 3'h0);
  endproperty
  a_par_fault: assert property (p_par_fault) else $error("fault detection on in parallel mode");

  property p_gain_dec;
    (gain_code == GC_X50) |=> (gain_value == GV_X50);
  endproperty
  a_gain_dec: assert property (p_gain_dec) else $error("gain code 010 not decoded to 50");

  property p_gain_top;
    (gain_code == GC_X1000) |=> (gain_value == GV_X1000) && !ext_gain_path;
  endproperty
  a_gain_top: assert property (p_gain_top) else $error("gain code 110 not decoded to 1000");

  property p_ext_path;
    (gain_code == GC_EXT) |=> ext_gain_path;
  endproperty
  a_ext_path: assert property (p_ext_path) else $error("code 111 missed external path");

  property p_ser_reg;
    is_ser && $stable(mode_reg) |=> (ctrl_word == $past(hold_reg));
  endproperty
  a_ser_reg: assert property (p_ser_reg) else $error("serial word not applied");

  property p_sdo_oe;
    serial_out_oe |-> is_ser && !sel_prev_reg;
  endproperty
  a_sdo_oe: assert property (p_sdo_oe) else $error("serial out driven outside a frame");

  property p_hold_only_serial;
    $changed(hold_reg) |-> $past(do_load);
  endproperty
  a_hold_only_serial: assert property (p_hold_only_serial) else $error("holding reg changed without load");

  property p_auto_comp;
    (mode_reg == MODE_PARALLEL) && (pin_gain == GC_X200) |=> (comp_code == COMP_LOW);
  endproperty
  a_auto_comp: assert property (p_auto_comp) else $error("auto compensation wrong for 200");

  property p_arm;
    is_ser && sel_fall && lvl_b_s && !lvl_a_s |=> armed_reg;
  endproperty
  a_arm: assert property (p_arm) else $error("falling select did not arm");

  property p_shift;
    do_shift |=> (shift_reg == {$past(shift_reg[CTRL_W-2:0]), $past(sdi_s)});
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted on clock rise");

  property p_load;
    do_load |=> (hold_reg == $past(shift_reg)) ##1 (!$past(is_ser) || (ctrl_word == $past(hold_reg)));
  endproperty
  a_load: assert property (p_load) else $error("shift not copied on select rise");

  property p_sdo;
    do_shift ##1 1'b1 |=> (serial_out == $past(shift_reg[CTRL_W-1]));
  endproperty
  a_sdo: assert property (p_sdo) else $error("serial out not the far bit");

  c_serial_write: cover property (do_load);
  c_par_pd: cover property ((mode_reg == MODE_PARALLEL) && power_down);
  c_ext_gain: cover property (ext_gain_path && is_ser);
  c_mode_swap: cover property ((mode_reg == MODE_PARALLEL) ##1 (mode_reg == MODE_SERIAL));

endmodule
`default_nettype wire

// >>> design/gci_pkg.sv
// Constants shared by the gain configuration front end.
// Assumes one 50 MHz clock domain; pin levels arrive unsynchronised.
package gci_pkg;

  typedef enum logic {
    MODE_SERIAL,
    MODE_PARALLEL
  } gci_mode_t;

  // Control word layout
  localparam int          CTRL_W    = 16;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam int          GAIN_LSB  = 0;
  localparam int          GAIN_W    = 3;
  localparam int          COMP_LSB  = 3;
  localparam int          COMP_W    = 3;
  localparam int          MUX_LSB   = 6;
  localparam int          MUX_W     = 2;
  localparam int          POL_BIT   = 8;
  localparam int          PD_BIT    = 9;
  localparam int          FILT_BIT  = 10;
  localparam int          FPIN_BIT  = 11;
  localparam int          FCUR_LSB  = 12;
  localparam int          FCUR_W    = 3;
  localparam int          SPARE_BIT = 15;

  // Gain codes
  localparam logic [2:0] GC_X10   = 3'h0;
  localparam logic [2:0] GC_X20   = 3'h1;
  localparam logic [2:0] GC_X50   = 3'h2;
  localparam logic [2:0] GC_X100  = 3'h3;
  localparam logic [2:0] GC_X200  = 3'h4;
  localparam logic [2:0] GC_X500  = 3'h5;
  localparam logic [2:0] GC_X1000 = 3'h6;
  localparam logic [2:0] GC_EXT   = 3'h7;

  // Decoded gain factors; zero marks the external-resistor path
  localparam int         GV_W      = 10;
  localparam logic [9:0] GV_X10    = 10'h00A;
  localparam logic [9:0] GV_X20    = 10'h014;
  localparam logic [9:0] GV_X50    = 10'h032;
  localparam logic [9:0] GV_X100   = 10'h064;
  localparam logic [9:0] GV_X200   = 10'h0C8;
  localparam logic [9:0] GV_X500   = 10'h1F4;
  localparam logic [9:0] GV_X1000  = 10'h3E8;
  localparam logic [9:0] GV_EXT    = 10'h000;

  // Automatic compensation codes; low two bits of COMP_EXT are don't-care
  localparam logic [2:0] COMP_WIDE = 3'h0;
  localparam logic [2:0] COMP_MID  = 3'h1;
  localparam logic [2:0] COMP_LOW  = 3'h2;
  localparam logic [2:0] COMP_MIN  = 3'h3;
  localparam logic [2:0] COMP_EXT  = 3'h4;

  // Pins passed through the synchroniser
  localparam int SYNC_W = 6;

endpackage

// >>> design/gci_sync.sv
// Two-flop synchroniser, one chain per bit.
// Assumes inputs are asynchronous levels; outputs are in clk domain.
`timescale 1ns/1ns
`default_nettype none
module gci_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import gci_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // Resets high, the idle level of select and clock, so no false edge follows reset
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> design/gci_gain_decode.sv
// Gain code decoder: gain factor, automatic compensation, path select.
// Purely combinational; the caller registers what it presents.
`timescale 1ns/1ns
`default_nettype none
module gci_gain_decode (
  input  wire logic [gci_pkg::GAIN_W-1:0] gain_code,
  output logic      [gci_pkg::GV_W-1:0]   gain_value,
  output logic      [gci_pkg::COMP_W-1:0] comp_auto,
  output logic                            ext_path
);
  import gci_pkg::*;

  always_comb begin
    gain_value = GV_EXT;
    comp_auto  = COMP_EXT;
    case (gain_code)
      GC_X10: begin
        gain_value = GV_X10;
        comp_auto  = COMP_WIDE;
      end
      GC_X20: begin
        gain_value = GV_X20;
        comp_auto  = COMP_WIDE;
      end
      GC_X50: begin
        gain_value = GV_X50;
        comp_auto  = COMP_MID;
      end
      GC_X100: begin
        gain_value = GV_X100;
        comp_auto  = COMP_LOW;
      end
      GC_X200: begin
        gain_value = GV_X200;
        comp_auto  = COMP_LOW;
      end
      GC_X500: begin
        gain_value = GV_X500;
        comp_auto  = COMP_MIN;
      end
      GC_X1000: begin
        gain_value = GV_X1000;
        comp_auto  = COMP_MIN;
      end
      default: begin
        gain_value = GV_EXT;
        comp_auto  = COMP_EXT;
      end
    endcase
  end

  assign ext_path = (gain_code == GC_EXT);

endmodule
`default_nettype wire

// >>> bench/gci_host_model.sv
// Host side of the four shared pins: serial frames or parallel levels.
// Assumes clk is the bench clock; every pin change lands 2 ns after its rise.
`timescale 1ns/1ns
`default_nettype none
module gci_host_model (
  input  wire logic clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output var logic  select_n,
  output var logic  serial_clk,
  output var logic  serial_in,
  output var logic  gain_lsb,
  output var logic  par_drive
);
  initial begin
    select_n   = 1'b1;
    serial_clk = 1'b1;
    serial_in  = 1'b0;
    gain_lsb   = 1'b0;
    par_drive  = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Link clock phases of 4 cycles give a 160 ns period
  task automatic frame(input logic bits[$], output logic [1:0] seen[$]);
    seen = {};
    par_drive  = 1'b0;
    serial_clk = 1'b1;
    step(4);
    select_n = 1'b0;
    step(4);
    foreach (bits[i]) begin
      serial_clk = 1'b0;
      serial_in  = bits[i];
      step(4);
      seen.push_back({serial_out_oe, serial_out});
      serial_clk = 1'b1;
      step(4);
    end
    select_n  = 1'b1;
    serial_in = ~serial_in;
    step(4);
  endtask

  // Clock pulses with the device not selected
  task automatic stray(input int n);
    repeat (n) begin
      serial_clk = 1'b0;
      serial_in  = ~serial_in;
      step(4);
      serial_clk = 1'b1;
      step(4);
    end
  endtask

  task automatic levels(input logic [2:0] code, input logic pd);
    par_drive  = 1'b1;
    select_n   = pd;
    serial_clk = code[2];
    serial_in  = code[1];
    gain_lsb   = code[0];
  endtask

  task automatic idle();
    par_drive  = 1'b0;
    select_n   = 1'b1;
    serial_clk = 1'b1;
    step(4);
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_gci_config.sv
// Self-checking bench for the configuration front end, with a shift model.
// Assumes gci_pkg and the host model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_gci_config;
  import gci_pkg::*;
  logic        clk, nrst, lvl_a, lvl_b;
  wire logic   select_n, serial_clk, serial_in, gain_lsb, par_drive, pin14;
  logic        serial_out, serial_out_oe, serial_mode, ext_gain_path, polarity_swap, power_down;
  logic        filter_en, fault_pin_sel;
  logic [2:0]  gain_code, comp_code, fault_current;
  logic [1:0]  mux_sel;
  logic [9:0]  gain_value;
  logic [15:0] ctrl_word, m_sr, m_hold, rnd;
  int          n_fail, checks;
  logic [9:0]  gv_t [8] = '{GV_X10, GV_X20, GV_X50, GV_X100, GV_X200, GV_X500, GV_X1000, GV_EXT};
  logic [2:0]  comp_t [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};

  // Pin 14 level; an undriven line shows the inverse of the last value
  assign pin14 = serial_out_oe ? serial_out : (par_drive ? gain_lsb : ~serial_out);

  gci_host_model host (.clk(clk), .serial_out(pin14), .serial_out_oe(serial_out_oe), .select_n(select_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .gain_lsb(gain_lsb), .par_drive(par_drive));

  gci_config dut (.clk(clk), .nrst(nrst), .mode_level_pin_a(lvl_a), .mode_level_pin_b(lvl_b),
    .select_n(select_n), .serial_clk(serial_clk), .serial_in(serial_in), .serial_out_in(pin14),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .serial_mode(serial_mode),
    .gain_code(gain_code), .gain_value(gain_value), .ext_gain_path(ext_gain_path), .comp_code(comp_code),
    .mux_sel(mux_sel), .polarity_swap(polarity_swap), .power_down(power_down), .filter_en(filter_en),
    .fault_pin_sel(fault_pin_sel), .fault_current(fault_current), .ctrl_word(ctrl_word));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (e !== g) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_all(input logic [15:0] w, input logic smode);
    chk("ctrl_word", w, ctrl_word);
    chk("gain_code", 16'(w[GAIN_LSB +: GAIN_W]), 16'(gain_code));
    chk("gain_value", 16'(gv_t[w[2:0]]), 16'(gain_value));
    chk("ext_gain_path", 16'(w[2:0] == GC_EXT), 16'(ext_gain_path));
    chk("comp_code", 16'(w[COMP_LSB +: COMP_W]), 16'(comp_code));
    chk("mux_sel", 16'(w[MUX_LSB +: MUX_W]), 16'(mux_sel));
    chk("polarity_swap", 16'(w[POL_BIT]), 16'(polarity_swap));
    chk("power_down", 16'(w[PD_BIT]), 16'(power_down));
    chk("filter_en", 16'(w[FILT_BIT]), 16'(filter_en));
    chk("fault_pin_sel", 16'(w[FPIN_BIT]), 16'(fault_pin_sel));
    chk("fault_current", 16'(w[FCUR_LSB +: FCUR_W]), 16'(fault_current));
    chk("serial_mode", 16'(smode), 16'(serial_mode));
    chk("serial_out_oe", 16'h0000, 16'(serial_out_oe));
  endtask

  task automatic settle(input logic [15:0] w, input logic smode);
    int k;
    k = 0;
    while (ctrl_word !== w && k < 20) begin
      @(posedge clk);
      #2;
      k++;
    end
    if (ctrl_word !== w) begin
      n_fail++;
      $display("[FAIL] ctrl_word wait expected %h seen %h", w, ctrl_word);
      tally_and_finish();
    end
    repeat (2) @(posedge clk);
    #2;
    check_all(w, smode);
  endtask

  task automatic send(input logic bits[$]);
    logic [1:0]  seen[$];
    logic [15:0] exp_sr;
    exp_sr = m_sr;
    host.frame(bits, seen);
    foreach (bits[i]) begin
      chk("serial_out_oe", 16'h0001, 16'(seen[i][1]));
      chk("serial_out", 16'(exp_sr[15]), 16'(seen[i][0]));
      exp_sr = {exp_sr[14:0], bits[i]};
    end
    m_sr   = exp_sr;
    m_hold = exp_sr;
    settle(m_hold, 1'b1);
  endtask

  // Random bits of any count, the last three the gain code; a word of 16 when n is 16
  task automatic send_rand(input int n, input logic [2:0] code);
    logic bits[$];
    bits = {};
    rnd  = lfsr(rnd);
    for (int i = 0; i < n; i++) begin
      bits.push_back(i >= n - 3 ? code[n - 1 - i] : rnd[i % 16]);
    end
    send(bits);
  endtask

  function automatic logic [15:0] pword(input logic [2:0] c, input logic pd);
    pword = 16'h0000;
    pword[GAIN_LSB +: GAIN_W] = c;
    pword[COMP_LSB +: COMP_W] = comp_t[c];
    pword[PD_BIT] = pd;
  endfunction

  initial begin
    #1000000;
    n_fail++;
    $display("[FAIL] watchdog expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    nrst   = 1'b0;
    lvl_a  = 1'b0;
    lvl_b  = 1'b1;
    n_fail = 0;
    checks = 0;
    m_sr   = 16'h0000;
    m_hold = 16'h0000;
    rnd    = 16'h001F;
    repeat (10) @(posedge clk);
    #2;
    nrst = 1'b1;
    settle(16'h0000, 1'b1);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      send_rand(16, 3'(c));
    end
    $display("test serial words done");
    host.stray(3);
    settle(m_hold, 1'b1);
    lvl_a = 1'b1;
    host.step(6);
    settle(m_hold, 1'b1);
    lvl_a = 1'b0;
    send_rand(8, GC_X500);
    send_rand(20, GC_EXT);
    $display("test frame lengths done");
    lvl_a = 1'b1;
    lvl_b = 1'b0;
    host.step(6);
    for (int c = 0; c < 16; c++) begin
      host.levels(3'(c), c[3]);
      settle(pword(3'(c), c[3]), 1'b0);
    end
    $display("test parallel done");
    host.idle();
    lvl_a = 1'b0;
    lvl_b = 1'b1;
    settle(m_hold, 1'b1);
    nrst = 1'b0;
    host.step(3);
    nrst   = 1'b1;
    m_sr   = 16'h0000;
    m_hold = 16'h0000;
    settle(16'h0000, 1'b1);
    send_rand(16, GC_X20);
    $display("test return to serial done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
